// ===== rtl/tt_timer_two_map.svh
// register offsets, field positions, reset values and divide counts of the timer
`ifndef TT_TIMER_TWO_MAP_SVH
`define TT_TIMER_TWO_MAP_SVH
`define TT_ADDR_W 3
`define TT_OFF_CONTROL 3'h0
`define TT_OFF_MODE 3'h1
`define TT_OFF_CNT_LO 3'h2
`define TT_OFF_CNT_HI 3'h3
`define TT_OFF_CAP_LO 3'h4
`define TT_OFF_CAP_HI 3'h5
`define TT_OFF_INT_STAT 3'h6
`define TT_OFF_INT_MASK 3'h7
`define TT_CTL_OVF 7
`define TT_CTL_EXT 6
`define TT_CTL_RCLK 5
`define TT_CTL_TRANSMIT_CLOCK_SELECT 4
`define TT_CTL_EXEN 3
`define TT_CTL_RUN 2
`define TT_CTL_CSEL 1
`define TT_CTL_CPRL 0
`define TT_MODE_DOWN_COUNT_ENABLE 0
`define TT_MODE_TWELVE 1
`define TT_INT_OVF 0
`define TT_INT_EXT 1
`define TT_RST_CONTROL 8'h00
`define TT_RST_MODE 8'h00
`define TT_RST_CNT 16'h0000
`define TT_CNT_TOP 16'hFFFF
`define TT_DIV_SIX 6
`define TT_DIV_TWELVE 12
`endif

// ===== rtl/tt_pkg.sv
// types shared by the timer two block
package tt_pkg;
  typedef enum logic [2:0] {
    TT_OFF = 3'b000,
    TT_AUTO = 3'b001,
    TT_UPDN = 3'b010,
    TT_CAPT = 3'b011,
    TT_BAUD = 3'b100
  } tt_mode_t;
endpackage

// ===== rtl/tt_timer_two.sv
// timer two: 16-bit timer/counter with capture, auto-reload, up/down and baud modes
//
// Behaviour
// [R1] 16-bit up or down counter, timer or event counter chosen by counter_select.
// [R2] timer counts clock divided by 6 or 12; counter counts count-pin falling edges.
// [R3] modes: capture, auto-reload up or up/down, baud-rate generation.
// [R4] run_control one starts counting; zero stops the timer whatever else is set.
// [R5] capture mode without external_enable: overflow sets overflow_flag.
// [R6] capture mode with external_enable: falling edge copies count, sets external_flag.
// [R7] capture leaves the counter running undisturbed; capture mode never reloads.
// [R8] either flag requests the one shared interrupt; software checks both flags.
// [R9] down_count_enable resets to zero, so auto-reload counts up only.
// [R10] up-only auto-reload overflows at FFFF, sets overflow_flag, loads reload value.
// [R11] up-only with external_enable: edge_direction falling edge reloads, sets external_flag.
// [R12] up/down with direction high counts up, overflow at FFFF reloads, sets flag.
// [R13] up/down with direction low counts down, at reload value loads FFFF.
// [R14] up/down: external_flag toggles each wrap and requests no interrupt.
// [R15] overflow_flag cleared only by software, never set in baud mode.
// [R16] external_flag stays set until software clears it or an up/down wrap toggles it.
// [R17] receive clock select picks this timer's overflow, else the other timer's.
// [R18] count and direction pins sampled on clk; falling edge is high then low.
// [R19] baud mode reloads on every overflow and passes each overflow on.
`include "tt_timer_two_map.svh"
`timescale 1ns/10ps
`default_nettype none
module tt_timer_two #(
  parameter int CNT_W = 16,
  parameter int DIV_SIX = `TT_DIV_SIX,
  parameter int DIV_TWELVE = `TT_DIV_TWELVE
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [`TT_ADDR_W-1:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  input wire logic count_pin_i,
  input wire logic edge_direction_input_i,
  input wire logic other_timer_ovf_i,
  output logic rx_baud_tick_o,
  output logic tx_baud_tick_o,
  output logic irq_o
);

  initial begin
    if (CNT_W != 16 || DIV_SIX < 2 || DIV_TWELVE < 2 || DIV_TWELVE > 255 || DIV_SIX > 255) begin
      $error("tt_timer_two: unsupported parameter values");
    end
  end

  logic [7:0] ctl_r;
  logic [7:0] mode_r;
  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cap_r;
  logic [1:0] istat_r;
  logic [1:0] imask_r;
  logic [7:0] presc_r;
  logic cpin_s_r;
  logic cpin_p_r;
  logic dir_s_r;
  logic dir_p_r;

  function automatic logic hit(input logic [`TT_ADDR_W-1:0] a,
                               input logic [`TT_ADDR_W-1:0] off,
                               input logic strobe);
    hit = strobe && (a == off);
  endfunction

  logic wr_ctl, wr_mode, wr_clo, wr_chi, wr_rlo, wr_rhi, wr_ist, wr_imk;
  assign wr_ctl = hit(addr_i, `TT_OFF_CONTROL, wr_i);
  assign wr_mode = hit(addr_i, `TT_OFF_MODE, wr_i);
  assign wr_clo = hit(addr_i, `TT_OFF_CNT_LO, wr_i);
  assign wr_chi = hit(addr_i, `TT_OFF_CNT_HI, wr_i);
  assign wr_rlo = hit(addr_i, `TT_OFF_CAP_LO, wr_i);
  assign wr_rhi = hit(addr_i, `TT_OFF_CAP_HI, wr_i);
  assign wr_ist = hit(addr_i, `TT_OFF_INT_STAT, wr_i);
  assign wr_imk = hit(addr_i, `TT_OFF_INT_MASK, wr_i);

  logic run, csel, exen, baud, down_count_enable, twelve;
  assign run = ctl_r[`TT_CTL_RUN];
  assign csel = ctl_r[`TT_CTL_CSEL];
  assign exen = ctl_r[`TT_CTL_EXEN];
  assign baud = ctl_r[`TT_CTL_RCLK] | ctl_r[`TT_CTL_TRANSMIT_CLOCK_SELECT];
  assign down_count_enable = mode_r[`TT_MODE_DOWN_COUNT_ENABLE];
  assign twelve = mode_r[`TT_MODE_TWELVE];

  // [R3] mode decode
  tt_pkg::tt_mode_t mode;
  always_comb begin
    if (!run) begin
      mode = tt_pkg::TT_OFF;
    end else if (baud) begin
      mode = tt_pkg::TT_BAUD;
    end else if (ctl_r[`TT_CTL_CPRL]) begin
      mode = tt_pkg::TT_CAPT;
    end else if (down_count_enable) begin
      mode = tt_pkg::TT_UPDN;
    end else begin
      mode = tt_pkg::TT_AUTO;
    end
  end

  // [R18] pin sampling
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cpin_s_r <= 1'b0;
      cpin_p_r <= 1'b0;
      dir_s_r <= 1'b0;
      dir_p_r <= 1'b0;
    end else begin
      cpin_s_r <= count_pin_i;
      cpin_p_r <= cpin_s_r;
      dir_s_r <= edge_direction_input_i;
      dir_p_r <= dir_s_r;
    end
  end

  logic cpin_fall, dir_fall;
  assign cpin_fall = cpin_p_r & ~cpin_s_r;
  assign dir_fall = dir_p_r & ~dir_s_r;

  // [R2] prescaler for timer use
  logic [7:0] div_last;
  logic presc_tick;
  assign div_last = twelve ? 8'(DIV_TWELVE - 1) : 8'(DIV_SIX - 1);
  assign presc_tick = (presc_r >= div_last);
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      presc_r <= 8'h00;
    end else if (!run || presc_tick) begin
      presc_r <= 8'h00;
    end else begin
      presc_r <= presc_r + 8'h01;
    end
  end

  // [R4] nothing counts while stopped
  logic tick, up, ovf, ext_ev, tf_set, ef_set, ef_tog;
  assign tick = run && (csel ? cpin_fall : presc_tick);
  // [R12] direction pin steers only in up/down
  assign up = (mode != tt_pkg::TT_UPDN) || dir_s_r;
  assign ovf = tick && (up ? (cnt_r == `TT_CNT_TOP) : (cnt_r == cap_r));
  assign ext_ev = run && exen && dir_fall && (mode != tt_pkg::TT_UPDN);
  // [R15] no overflow flag in baud mode
  assign tf_set = ovf && (mode != tt_pkg::TT_BAUD);
  assign ef_set = ext_ev;
  assign ef_tog = ovf && (mode == tt_pkg::TT_UPDN);

  // [R1] sixteen-bit count; a software byte write wins over counting
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_r <= `TT_RST_CNT;
    end else if (wr_clo) begin
      cnt_r[7:0] <= wdata_i;
    end else if (wr_chi) begin
      cnt_r[15:8] <= wdata_i;
    end else begin
      case (mode)
        tt_pkg::TT_OFF: begin
          cnt_r <= cnt_r;
        end
        // [R7] capture keeps counting, wraps without reload
        tt_pkg::TT_CAPT: begin
          if (tick) begin
            cnt_r <= cnt_r + 16'h0001;
          end
        end
        tt_pkg::TT_AUTO: begin
          // [R11] external reload
          if (ext_ev) begin
            cnt_r <= cap_r;
          // [R10] overflow reload
          end else if (ovf) begin
            cnt_r <= cap_r;
          end else if (tick) begin
            cnt_r <= cnt_r + 16'h0001;
          end
        end
        tt_pkg::TT_UPDN: begin
          // [R13] underflow loads top
          if (ovf) begin
            cnt_r <= up ? cap_r : `TT_CNT_TOP;
          end else if (tick) begin
            cnt_r <= up ? cnt_r + 16'h0001 : cnt_r - 16'h0001;
          end
        end
        // [R19] baud reload on every overflow
        tt_pkg::TT_BAUD: begin
          if (ovf) begin
            cnt_r <= cap_r;
          end else if (tick) begin
            cnt_r <= cnt_r + 16'h0001;
          end
        end
        default: begin
          cnt_r <= cnt_r;
        end
      endcase
    end
  end

  // [R6] capture copy wins over a software write
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      cap_r <= `TT_RST_CNT;
    end else if (ext_ev && mode == tt_pkg::TT_CAPT) begin
      cap_r <= cnt_r;
    end else if (wr_rlo) begin
      cap_r[7:0] <= wdata_i;
    end else if (wr_rhi) begin
      cap_r[15:8] <= wdata_i;
    end
  end

  // control register; hardware set wins over a software clear
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctl_r <= `TT_RST_CONTROL;
    end else begin
      if (wr_ctl) begin
        ctl_r[5:0] <= wdata_i[5:0];
      end
      // [R5] overflow sets the flag; only software clears it
      if (tf_set) begin
        ctl_r[`TT_CTL_OVF] <= 1'b1;
      end else if (wr_ctl) begin
        ctl_r[`TT_CTL_OVF] <= wdata_i[`TT_CTL_OVF];
      end
      // [R16] external flag sticky
      if (ef_set) begin
        ctl_r[`TT_CTL_EXT] <= 1'b1;
      // [R14] seventeenth count bit
      end else if (ef_tog) begin
        ctl_r[`TT_CTL_EXT] <= ~ctl_r[`TT_CTL_EXT];
      end else if (wr_ctl) begin
        ctl_r[`TT_CTL_EXT] <= wdata_i[`TT_CTL_EXT];
      end
    end
  end

  // [R9] down count disabled from reset
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mode_r <= `TT_RST_MODE;
    end else if (wr_mode) begin
      mode_r <= {6'h00, wdata_i[1:0]};
    end
  end

  // [R8] shared interrupt; toggles in up/down are not requests
  logic irq_raw;
  assign irq_raw = |(istat_r & imask_r);
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      istat_r <= 2'b00;
      imask_r <= 2'b00;
      irq_o <= 1'b0;
    end else begin
      istat_r[`TT_INT_OVF] <= tf_set | (istat_r[`TT_INT_OVF] & ~(wr_ist & wdata_i[`TT_INT_OVF]));
      istat_r[`TT_INT_EXT] <= ef_set | (istat_r[`TT_INT_EXT] & ~(wr_ist & wdata_i[`TT_INT_EXT]));
      if (wr_imk) begin
        imask_r <= wdata_i[1:0];
      end
      irq_o <= irq_raw;
    end
  end

  // [R17] serial clock source select
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rx_baud_tick_o <= 1'b0;
      tx_baud_tick_o <= 1'b0;
    end else begin
      rx_baud_tick_o <= ctl_r[`TT_CTL_RCLK] ? (ovf && mode == tt_pkg::TT_BAUD) : other_timer_ovf_i;
      tx_baud_tick_o <= ctl_r[`TT_CTL_TRANSMIT_CLOCK_SELECT] ? (ovf && mode == tt_pkg::TT_BAUD) : other_timer_ovf_i;
    end
  end

  // read data stands one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        `TT_OFF_CONTROL: rdata_o <= ctl_r;
        `TT_OFF_MODE: rdata_o <= mode_r;
        `TT_OFF_CNT_LO: rdata_o <= cnt_r[7:0];
        `TT_OFF_CNT_HI: rdata_o <= cnt_r[15:8];
        `TT_OFF_CAP_LO: rdata_o <= cap_r[7:0];
        `TT_OFF_CAP_HI: rdata_o <= cap_r[15:8];
        `TT_OFF_INT_STAT: rdata_o <= {6'h00, istat_r};
        `TT_OFF_INT_MASK: rdata_o <= {6'h00, imask_r};
        default: rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  logic cnt_wr;
  assign cnt_wr = wr_clo | wr_chi;

  property p_off_holds;
    (!run && !cnt_wr) |=> (cnt_r == $past(cnt_r));
  endproperty
  a_off_holds: assert property (p_off_holds) else $error("counter moved while stopped"); // [R4]

  property p_six_div;
    (run && !csel && !twelve && !wr_ctl && !wr_mode && presc_tick) |=> !presc_tick [*5];
  endproperty
  a_six_div: assert property (p_six_div) else $error("divide by six spacing wrong"); // [R2]

  property p_capt_ovf;
    (mode == tt_pkg::TT_CAPT && ovf) |=> ctl_r[`TT_CTL_OVF];
  endproperty
  a_capt_ovf: assert property (p_capt_ovf) else $error("overflow flag not set"); // [R5]

  property p_capture;
    (mode == tt_pkg::TT_CAPT && ext_ev) |=> (cap_r == $past(cnt_r)) && ctl_r[`TT_CTL_EXT];
  endproperty
  a_capture: assert property (p_capture) else $error("capture did not copy count"); // [R6]

  property p_capt_undisturbed;
    (mode == tt_pkg::TT_CAPT && ext_ev && !tick && !cnt_wr) |=> (cnt_r == $past(cnt_r));
  endproperty
  a_capt_undisturbed: assert property (p_capt_undisturbed) else $error("capture disturbed count"); // [R7]

  property p_irq;
    irq_o == $past(irq_raw);
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt output mismatch"); // [R8]

  property p_up_reload;
    (mode == tt_pkg::TT_AUTO && ovf && !ext_ev && !cnt_wr) |=> (cnt_r == $past(cap_r));
  endproperty
  a_up_reload: assert property (p_up_reload) else $error("overflow reload wrong"); // [R10]

  property p_ext_reload;
    (mode == tt_pkg::TT_AUTO && ext_ev && !cnt_wr) |=> (cnt_r == $past(cap_r)) && ctl_r[`TT_CTL_EXT];
  endproperty
  a_ext_reload: assert property (p_ext_reload) else $error("edge reload wrong"); // [R11]

  property p_up_wrap;
    (mode == tt_pkg::TT_UPDN && ovf && up && !cnt_wr) |=> (cnt_r == $past(cap_r));
  endproperty
  a_up_wrap: assert property (p_up_wrap) else $error("up count overflow reload wrong"); // [R12]

  property p_down_under;
    (mode == tt_pkg::TT_UPDN && ovf && !up && !cnt_wr) |=> (cnt_r == `TT_CNT_TOP);
  endproperty
  a_down_under: assert property (p_down_under) else $error("underflow did not load top"); // [R13]

  property p_updn_toggle;
    (ef_tog && !ef_set) |=> (ctl_r[`TT_CTL_EXT] != $past(ctl_r[`TT_CTL_EXT])) && !istat_r[`TT_INT_EXT] || $past(istat_r[`TT_INT_EXT]);
  endproperty
  a_updn_toggle: assert property (p_updn_toggle) else $error("external flag toggle wrong"); // [R14]

  property p_no_tf_baud;
    (baud && !ctl_r[`TT_CTL_OVF] && !wr_ctl) |=> !ctl_r[`TT_CTL_OVF];
  endproperty
  a_no_tf_baud: assert property (p_no_tf_baud) else $error("overflow flag set in baud mode"); // [R15]

  // flag only moves by a set, a toggle or a software write
  property p_ext_sticky;
    (ctl_r[`TT_CTL_EXT] && !wr_ctl && !ef_tog) |=> ctl_r[`TT_CTL_EXT];
  endproperty
  a_ext_sticky: assert property (p_ext_sticky) else $error("external flag dropped"); // [R16]

  property p_baud_tick;
    (mode == tt_pkg::TT_BAUD && ovf && ctl_r[`TT_CTL_RCLK]) |=> rx_baud_tick_o;
  endproperty
  a_baud_tick: assert property (p_baud_tick) else $error("baud overflow not passed on"); // [R17]

  c_capture: cover property (mode == tt_pkg::TT_CAPT && ext_ev);
  c_underflow: cover property (mode == tt_pkg::TT_UPDN && ovf && !up);
  c_baud: cover property (mode == tt_pkg::TT_BAUD && ovf);
  c_irq: cover property (irq_o);

endmodule
`default_nettype wire

// ===== dv/tt_pin_model.sv
// far-side model driving the external count pin and the edge/direction pin
`timescale 1ns/10ps
`default_nettype none
module tt_pin_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic pulse_req_i,
  input wire logic dir_req_i,
  output logic count_pin_o,
  output logic edge_dir_o
);
  logic [1:0] low_r;
  // pins change just after an edge
  // low for three cycles so a single-sample detector never misses it
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      low_r <= 2'h0;
    end else if (pulse_req_i) begin
      low_r <= 2'h3;
    end else if (low_r != 2'h0) begin
      low_r <= low_r - 2'h1;
    end
  end
  // idle high, falling edge per request
  assign count_pin_o = (low_r == 2'h0);
  // direction level held by the bench request
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      edge_dir_o <= 1'b1;
    end else begin
      edge_dir_o <= dir_req_i;
    end
  end
endmodule
`default_nettype wire

// ===== dv/testbench.sv
// self-checking bench for the timer two block
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic clk_i, rst_i, wr_i, rd_i, pulse_req, dir_req, other_ovf, rd_seen;
  logic [2:0] addr_i;
  logic [7:0] wdata_i;
  logic [7:0] rdata_o;
  logic count_pin, edge_dir, rx_tick, tx_tick, irq_o;
  logic [15:0] rv;
  logic [7:0] expq[$];
  int fail_count, n_checks, rx_n, tx_n, cyc;
  integer seed;

  tt_timer_two dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .count_pin_i(count_pin),
    .edge_direction_input_i(edge_dir), .other_timer_ovf_i(other_ovf),
    .rx_baud_tick_o(rx_tick), .tx_baud_tick_o(tx_tick), .irq_o(irq_o));
  tt_pin_model pins (.clk_i(clk_i), .rst_i(rst_i), .pulse_req_i(pulse_req),
    .dir_req_i(dir_req), .count_pin_o(count_pin), .edge_dir_o(edge_dir));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  // the expected byte is queued here, compared by the watcher below
  task automatic rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clk_i);
    expq.push_back(e);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  task automatic wr16(input logic [2:0] a, input logic [15:0] v);
    wr(a, v[7:0]);
    wr(a + 3'd1, v[15:8]);
  endtask

  task automatic pulse();
    @(posedge clk_i);
    pulse_req <= 1'b1;
    @(posedge clk_i);
    pulse_req <= 1'b0;
    wait_cyc(8);
  endtask

  // read data stand only in the cycle after the strobe
  always @(posedge clk_i) begin
    if (rd_seen === 1'b1) begin
      if (expq.size() > 0) begin
        check({8'h00, rdata_o}, {8'h00, expq.pop_front()});
      end
    end
    rd_seen <= rd_i;
    if (rx_tick === 1'b1) rx_n++;
    if (tx_tick === 1'b1) tx_n++;
    cyc++;
    if (cyc > 5000) begin
      fail_count++;
      report_and_stop();
    end
  end

  initial begin
    seed = 32'ha77d_c6e5;
    {rst_i, wr_i, rd_i, pulse_req, other_ovf} = 5'b10000;
    dir_req = 1'b1;
    addr_i = 3'h0;
    wdata_i = 8'h00;
    {fail_count, n_checks, rx_n, tx_n, cyc} = '0;
    wait_cyc(10);
    rst_i <= 1'b0;
    // all eight registers clear after reset
    for (int i = 0; i < 8; i++) begin
      rd(i[2:0], 8'h00);
    end
    $display("test reset done");

    // up-only reload from a random value, overflow flag and interrupt
    rv = 16'($random(seed)) & 16'hfff0;
    wr16(3'h4, rv);
    wr16(3'h2, 16'hffff);
    wr(3'h0, 8'h04);
    // stop again before the tick that follows the reload
    wait_cyc(6);
    rd(3'h0, 8'h84);
    wr(3'h0, 8'h80);
    rd(3'h2, rv[7:0]);
    rd(3'h3, rv[15:8]);
    rd(3'h6, 8'h01);
    check({15'h0, irq_o}, 16'h0000);
    wr(3'h7, 8'h03);
    wait_cyc(2);
    check({15'h0, irq_o}, 16'h0001);
    wr(3'h6, 8'h01);
    wait_cyc(2);
    check({15'h0, irq_o}, 16'h0000);
    rd(3'h0, 8'h80);
    $display("test auto reload done");

    // capture on a direction-pin fall leaves the counter alone
    wr(3'h0, 8'h00);
    wr16(3'h2, 16'h1000);
    wr(3'h0, 8'h0f);
    dir_req <= 1'b0;
    wait_cyc(6);
    dir_req <= 1'b1;
    rd(3'h4, 8'h00);
    rd(3'h5, 8'h10);
    rd(3'h0, 8'h4f);
    check({15'h0, irq_o}, 16'h0001);
    // event counting of count-pin falls in the same mode
    repeat (3) pulse();
    rd(3'h2, 8'h03);
    rd(3'h3, 8'h10);
    rd(3'h0, 8'h4f);
    $display("test capture done");

    // up/down: down to the reload value wraps to ffff, up wraps back
    wr(3'h0, 8'h00);
    wr(3'h6, 8'h03);
    wr(3'h1, 8'h01);
    wr16(3'h4, 16'h0005);
    wr16(3'h2, 16'h0005);
    dir_req <= 1'b0;
    wr(3'h0, 8'h06);
    pulse();
    rd(3'h2, 8'hff);
    rd(3'h3, 8'hff);
    rd(3'h0, 8'hc6);
    dir_req <= 1'b1;
    pulse();
    rd(3'h2, 8'h05);
    rd(3'h3, 8'h00);
    rd(3'h0, 8'h86);
    rd(3'h6, 8'h01);
    $display("test up down done");

    // baud mode: one tick each side, no overflow flag
    wr(3'h0, 8'h00);
    wr(3'h6, 8'h03);
    wr(3'h1, 8'h00);
    wr16(3'h2, 16'hffff);
    wr(3'h0, 8'h34);
    wait_cyc(10);
    rd(3'h0, 8'h34);
    wr(3'h0, 8'h00);
    check(rx_n[15:0], 16'h0001);
    check(tx_n[15:0], 16'h0001);
    rd(3'h6, 8'h00);
    // with the select bits clear the other timer drives the serial clock
    @(posedge clk_i);
    other_ovf <= 1'b1;
    @(posedge clk_i);
    other_ovf <= 1'b0;
    wait_cyc(3);
    check(rx_n[15:0], 16'h0002);
    check(tx_n[15:0], 16'h0002);
    $display("test baud done");

    // twelve-clock division: one tick in twenty cycles, six would give three
    wr(3'h1, 8'h02);
    wr16(3'h2, 16'h0000);
    wr(3'h0, 8'h04);
    wait_cyc(20);
    wr(3'h0, 8'h00);
    rd(3'h2, 8'h01);
    // up-only counter use with external_enable: a direction fall reloads
    wr16(3'h4, 16'h0123);
    wr(3'h0, 8'h0e);
    dir_req <= 1'b0;
    wait_cyc(6);
    dir_req <= 1'b1;
    rd(3'h2, 8'h23);
    rd(3'h3, 8'h01);
    rd(3'h0, 8'h4e);
    rd(3'h6, 8'h02);
    check({15'h0, irq_o}, 16'h0001);
    // capture mode without external_enable: wrap sets the flag, no reload
    wr16(3'h2, 16'hffff);
    wr(3'h0, 8'h07);
    pulse();
    rd(3'h2, 8'h00);
    rd(3'h3, 8'h00);
    rd(3'h4, 8'h23);
    rd(3'h0, 8'h87);
    $display("test twelve clock and edge reload done");
    wait_cyc(2);
    report_and_stop();
  end
endmodule
`default_nettype wire
